/* pkg/rte_pkg.sv */
package rte_pkg;
	// host port address of the control register
	localparam logic [11:0] CTRL_ADDR = 12'h900;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// control field positions
	localparam int HDLC_BYTE_BIT = 0;
	localparam int LEAD_LSB = 1;
	localparam int LEAD_MSB = 3;
	localparam int PKT_LSB = 4;
	localparam int PKT_MSB = 6;
	localparam int RSVD_BIT = 7;
	localparam int ENABLE_BIT = 8;
	localparam int ZSUB_BIT = 9;
	localparam int PAD_LSB = 10;
	localparam int PAD_MSB = 11;
	localparam int TEST_BIT = 15;
	// writable bits: 0..9, 10..11, 15
	localparam logic [15:0] CTRL_WMASK = 16'h8fff;
	// base frame length for packet count code 000
	localparam logic [10:0] PKT_BASE = 11'h020;
	localparam logic [2:0] PKT_CODE_MAX = 3'h5;
	// mu-law substitution values
	localparam logic [7:0] MU_ZERO = 8'h00;
	localparam logic [7:0] MU_ZERO_SUB = 8'h02;
	// even-bit inversion used for law conversion of padding
	localparam logic [7:0] LAW_XOR = 8'h55;
	// output law flag encoding
	localparam logic LAW_MU = 1'b0;
	localparam logic LAW_A = 1'b1;
	// pad companding codes
	typedef enum logic [1:0] {
		PAD_RAW = 2'h0,
		PAD_MU = 2'h1,
		PAD_ALAW = 2'h2,
		PAD_UNDEF = 2'h3
	} rte_pad_t;
	// buffer entry: frame_end, bitwise, hdlc, data
	localparam int ENTRY_W = 11;
endpackage

/* core/rte_egress.sv */
// Notes on behaviour
// - Bit 0 low frames HDLC bitwise on the TDM side; high frames bytewise.
// - Bits 6:4 pick 32 to 1024 packets per frame; codes 11x unused.
// - Incoming receive bytes are handled while enable bit 8 is set; in_ready follows the bit one cycle late, so one more byte can enter after it clears.
// - With bit 9 set, mu-law output byte 00h becomes 02h.
// - Bits 11:10: 00 raw padding ignoring law flag, 01 mu-law, 10 A-law.
`timescale 1ns/10ps
module rte_egress #(
	parameter int DATA_W = 8,
	parameter int PKT_CNT_W = 11
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// host microprocessor port
	input wire logic [11:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [15:0] cpu_rdata,
	output logic cpu_rvalid,
	// bytes from the receive reassembly
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [DATA_W-1:0] in_data,
	input wire logic in_last,
	input wire logic in_pad,
	input wire logic in_hdlc,
	input wire logic output_law_flag,
	// bytes toward the tdm backplane
	output logic out_valid,
	input wire logic out_ready,
	output logic [DATA_W-1:0] out_data,
	output logic out_hdlc,
	output logic out_bitwise,
	output logic out_frame_end,
	// slot lead setting to the tdm timing
	output logic [2:0] slot_lead
);
	localparam int EW = rte_pkg::ENTRY_W + DATA_W - 8;

	function automatic logic [PKT_CNT_W-1:0] frame_len(input logic [2:0] code);
		frame_len = PKT_CNT_W'(rte_pkg::PKT_BASE << code);
	endfunction

	function automatic logic [DATA_W-1:0] law_swap(input logic [DATA_W-1:0] b);
		law_swap = b ^ DATA_W'(rte_pkg::LAW_XOR);
	endfunction

	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [PKT_CNT_W-1:0] pkt_q;
	logic [PKT_CNT_W-1:0] pkt_d;
	logic [EW-1:0] e0_q;
	logic [EW-1:0] e1_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic in_ready_q;
	logic out_valid_q;

	// register decode
	wire ctrl_hit = cpu_addr == rte_pkg::CTRL_ADDR;
	wire ctrl_wr = cpu_wr & ctrl_hit;
	assign ctrl_d = (ctrl_q & ~rte_pkg::CTRL_WMASK) | (cpu_wdata & rte_pkg::CTRL_WMASK);

	// control fields
	wire bytewise = ctrl_q[rte_pkg::HDLC_BYTE_BIT];
	wire [2:0] pkt_code = ctrl_q[rte_pkg::PKT_MSB:rte_pkg::PKT_LSB];
	wire enable = ctrl_q[rte_pkg::ENABLE_BIT];
	wire zsub = ctrl_q[rte_pkg::ZSUB_BIT];
	rte_pkg::rte_pad_t pad_mode;
	assign pad_mode = rte_pkg::rte_pad_t'(ctrl_q[rte_pkg::PAD_MSB:rte_pkg::PAD_LSB]);

	wire push = in_valid & in_ready_q;
	wire pop = out_valid & out_ready;

	// padding translation toward the channel law
	wire pad_is_mu = pad_mode == rte_pkg::PAD_MU;
	wire pad_is_a = pad_mode == rte_pkg::PAD_ALAW;
	wire pad_law_differs = (pad_is_mu & (output_law_flag == rte_pkg::LAW_A)) |
		(pad_is_a & (output_law_flag == rte_pkg::LAW_MU));
	wire translate = in_pad & ~in_hdlc & pad_law_differs;
	wire [DATA_W-1:0] xlat_data = translate ? law_swap(in_data) : in_data;

	// law that governs the emitted byte; raw padding carries no law
	wire raw_pad = in_pad & (pad_mode == rte_pkg::PAD_RAW);
	wire out_is_mu = ~in_hdlc & ~raw_pad & (output_law_flag == rte_pkg::LAW_MU);

	wire zero_hit = zsub & out_is_mu & (xlat_data == DATA_W'(rte_pkg::MU_ZERO));
	wire [DATA_W-1:0] proc_data = zero_hit ? DATA_W'(rte_pkg::MU_ZERO_SUB) : xlat_data;

	wire [PKT_CNT_W-1:0] pkt_target = frame_len(pkt_code);
	wire pkt_wrap = in_last & (pkt_q == pkt_target - PKT_CNT_W'(1));
	assign pkt_d = pkt_wrap ? '0 : pkt_q + PKT_CNT_W'(in_last);
	wire pkt_code_change = ctrl_wr & (ctrl_d[rte_pkg::PKT_MSB:rte_pkg::PKT_LSB] != pkt_code);

	// framing granularity travels with each hdlc byte
	wire entry_bitwise = in_hdlc & ~bytewise;
	wire [EW-1:0] new_entry = {pkt_wrap, entry_bitwise, in_hdlc, proc_data};

	// two-entry buffer occupancy
	assign cnt_d = cnt_q + 2'(push) - 2'(pop);
	wire e0_load = (cnt_q == 2'h0) | (pop & (cnt_q == 2'h1));
	wire e1_load = push & ((cnt_q == 2'h1 & ~pop) | (cnt_q == 2'h2 & pop));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_q <= rte_pkg::CTRL_RESET;
		end else if (ce && ctrl_wr) begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cpu_rdata <= '0;
			cpu_rvalid <= 1'b0;
		end else if (ce) begin
			cpu_rvalid <= cpu_rd;
			cpu_rdata <= (cpu_rd && ctrl_hit) ? ctrl_q : 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pkt_q <= '0;
		end else if (ce && pkt_code_change) begin
			// counter never left beyond a shorter frame
			pkt_q <= '0;
		end else if (ce && push) begin
			pkt_q <= pkt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= 2'h0;
			in_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			out_valid_q <= cnt_d != 2'h0;
			in_ready_q <= enable & (cnt_d != 2'h2);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			e0_q <= '0;
			e1_q <= '0;
		end else if (ce) begin
			if (pop && cnt_q == 2'h2) begin
				e0_q <= e1_q;
			end else if (push && e0_load) begin
				e0_q <= new_entry;
			end
			if (e1_load) begin
				e1_q <= new_entry;
			end
		end
	end

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = e0_q[DATA_W-1:0];
	assign out_hdlc = e0_q[DATA_W];
	assign out_bitwise = e0_q[DATA_W+1];
	assign out_frame_end = e0_q[DATA_W+2];
	assign slot_lead = ctrl_q[rte_pkg::LEAD_MSB:rte_pkg::LEAD_LSB];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence accepted_zero_mu;
		push && ce && zsub && out_is_mu && xlat_data == DATA_W'(rte_pkg::MU_ZERO);
	endsequence

	sequence stalled_head;
		out_valid && !out_ready && ce;
	endsequence

	zero_sub_a: assert property (accepted_zero_mu |-> new_entry[DATA_W-1:0] == DATA_W'(rte_pkg::MU_ZERO_SUB))
		else $error("mu-law zero byte not replaced");
	no_sub_off_a: assert property (push && !zsub && !in_pad |-> new_entry[DATA_W-1:0] == in_data)
		else $error("byte altered with substitution off");
	disabled_idle_a: assert property (!enable && ce |=> !in_ready)
		else $error("bytes accepted while disabled");
	raw_pad_a: assert property (push && in_pad && pad_mode == rte_pkg::PAD_RAW
		|-> new_entry[DATA_W-1:0] == in_data)
		else $error("raw padding was translated");
	mu_pad_a: assert property (push && in_pad && !in_hdlc && pad_is_mu && output_law_flag == rte_pkg::LAW_A
		|-> new_entry[DATA_W-1:0] == (in_data ^ DATA_W'(rte_pkg::LAW_XOR)))
		else $error("mu-law padding not converted");
	granule_a: assert property (push && cnt_q == 2'h0 && ce ##1 1 |-> out_bitwise == ($past(in_hdlc) && !$past(bytewise)))
		else $error("framing granularity wrong");
	frame_len_a: assert property (push && ce && in_last && pkt_q == pkt_target - PKT_CNT_W'(1)
		|=> pkt_q == '0)
		else $error("frame packet count did not wrap");
	pkt_range_a: assert property (pkt_code <= rte_pkg::PKT_CODE_MAX |-> pkt_q < pkt_target)
		else $error("packet counter beyond frame length");
	buf_hold_a: assert property (stalled_head |=> out_valid && $stable(out_data))
		else $error("stalled byte lost");

	no_overrun_a: assert property (push |-> cnt_q != 2'h2)
		else $error("byte pushed into a full buffer");
	valid_mirror_a: assert property (out_valid == (cnt_q != 2'h0))
		else $error("output valid disagrees with occupancy");
	enable_write_a: assert property (ce && ctrl_wr |=> enable == $past(cpu_wdata[rte_pkg::ENABLE_BIT]))
		else $error("enable bit not written");
	ce_freeze_a: assert property (!ce |=> $stable(ctrl_q) && $stable(cnt_q) && $stable(pkt_q))
		else $error("state moved while clock enable low");
	alaw_keep_a: assert property (push && !in_pad && output_law_flag == rte_pkg::LAW_A
		|-> new_entry[DATA_W-1:0] == in_data)
		else $error("a-law byte altered");
	hdlc_keep_a: assert property (push && in_hdlc |-> new_entry[DATA_W-1:0] == in_data)
		else $error("hdlc byte altered");
	frame_end_a: assert property (push && in_last && pkt_code == 3'h0
		&& pkt_q == PKT_CNT_W'(rte_pkg::PKT_BASE) - PKT_CNT_W'(1) |-> new_entry[DATA_W+2])
		else $error("shortest frame not closed");
endmodule

/* test/rte_tdm_sink.sv */
`timescale 1ns/10ps
module rte_tdm_sink (
	// clock and pacing
	input wire logic clk,
	input wire logic slow,
	// stream from the egress stage
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [10:0] word
);
	logic [1:0] cnt_q = 2'h0;
	logic [10:0] got[$];
	initial out_ready = 1'b0;
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		// stall half of the time when slow
		out_ready <= !slow || cnt_q[1];
		if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(word);
	end
endmodule

/* test/rx_tdm_egress_control_test.sv */
`timescale 1ns/10ps
module rx_tdm_egress_control_test;
	logic clk = 1'b0, resetn = 1'b0, slow = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, in_valid = 1'b0;
	logic in_last = 1'b0, in_pad = 1'b0, in_hdlc = 1'b0, law = 1'b0, ce = 1'b1;
	logic [11:0] cpu_addr = 12'h000;
	logic [15:0] cpu_wdata = 16'h0000;
	logic [7:0] in_data = 8'h00;
	logic [15:0] cpu_rdata;
	logic cpu_rvalid, in_ready, out_valid, out_ready, out_hdlc, out_bitwise, out_frame_end;
	logic [7:0] out_data;
	logic [2:0] slot_lead;
	logic [10:0] exp[$];
	int mismatches = 0, check_count = 0, cycles = 0;
	always #5 clk = ~clk;
	rte_egress rte_egress_inst (.clk(clk), .resetn(resetn), .ce(ce), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.in_last(in_last), .in_pad(in_pad), .in_hdlc(in_hdlc), .output_law_flag(law),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_hdlc(out_hdlc),
		.out_bitwise(out_bitwise), .out_frame_end(out_frame_end), .slot_lead(slot_lead));
	rte_tdm_sink rte_tdm_sink_inst (.clk(clk), .slow(slow), .out_valid(out_valid), .out_ready(out_ready),
		.word({out_frame_end, out_bitwise, out_hdlc, out_data}));
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge clk);
		cpu_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge clk);
		cpu_rd <= 1'b0;
		#1;
		chk("rvalid", 16'h0001, {15'h0, cpu_rvalid});
		chk("rdata", e, cpu_rdata);
		@(posedge clk);
	endtask
	// f packs last, pad, hdlc, law; e packs frame end, bitwise, hdlc, byte
	task automatic send(input logic [3:0] f, input logic [7:0] d, input logic [10:0] e);
		{in_last, in_pad, in_hdlc, law} <= f;
		in_data <= d;
		in_valid <= 1'b1;
		exp.push_back(e);
		do @(posedge clk); while (in_ready !== 1'b1);
	endtask
	task automatic drain;
		in_valid <= 1'b0;
		while (rte_tdm_sink_inst.got.size() < exp.size()) @(posedge clk);
		foreach (exp[i]) chk("out word", {5'h0, exp[i]}, {5'h0, rte_tdm_sink_inst.got[i]});
		exp.delete();
		rte_tdm_sink_inst.got.delete();
		@(posedge clk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			finish_test;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(rte_pkg::CTRL_ADDR, rte_pkg::CTRL_RESET);
		rd(12'h902, 16'h0000);
		in_valid <= 1'b1;
		repeat (4) @(posedge clk);
		chk("in_ready", 16'h0000, {15'h0, in_ready});
		in_valid <= 1'b0;
		wr(rte_pkg::CTRL_ADDR, 16'h010e);
		rd(rte_pkg::CTRL_ADDR, 16'h010e);
		chk("slot_lead", 16'h0007, {13'h0, slot_lead});
		slow <= 1'b1;
		for (int i = 0; i < 32; i++) send(4'h8, 8'(i), {(i == 31), 2'h0, 8'(i)});
		drain;
		slow <= 1'b0;
		wr(rte_pkg::CTRL_ADDR, 16'h011e);
		for (int i = 0; i < 64; i++) send(4'h8, 8'(i), {(i == 63), 2'h0, 8'(i)});
		drain;
		wr(rte_pkg::CTRL_ADDR, 16'h070e);
		rd(rte_pkg::CTRL_ADDR, 16'h070e);
		send(4'h0, 8'h00, 11'h002);
		send(4'h5, 8'h00, 11'h055);
		send(4'h2, 8'h00, 11'h300);
		drain;
		wr(rte_pkg::CTRL_ADDR, 16'h0b0f);
		rd(rte_pkg::CTRL_ADDR, 16'h0b0f);
		send(4'h4, 8'h00, 11'h055);
		send(4'h5, 8'h11, 11'h011);
		send(4'h2, 8'h00, 11'h100);
		send(4'h1, 8'h00, 11'h000);
		drain;
		wr(rte_pkg::CTRL_ADDR, 16'h030e);
		send(4'h4, 8'h00, 11'h000);
		send(4'h5, 8'h3c, 11'h03c);
		send(4'h0, 8'h00, 11'h002);
		drain;
		ce <= 1'b0;
		wr(rte_pkg::CTRL_ADDR, 16'h0000);
		ce <= 1'b1;
		rd(rte_pkg::CTRL_ADDR, 16'h030e);
		wr(12'h902, 16'h0100);
		rd(rte_pkg::CTRL_ADDR, 16'h030e);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(rte_pkg::CTRL_ADDR, rte_pkg::CTRL_RESET);
		chk("slot_lead", 16'h0000, {13'h0, slot_lead});
		finish_test;
	end
endmodule
